// File: rtl/bma_pkg.sv
// Purpose: shared constants and types for the bus mastership arbiter
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: request and acknowledge inputs are active high inside the block
package bma_pkg;

  // ==========================================================================
  // timing
  localparam int BMA_CLK_PERIOD_NS = 100;
  localparam int BMA_SYNC_MAX_NS = 100;
  localparam int BMA_SYNC_MAX_CYC = (BMA_SYNC_MAX_NS / BMA_CLK_PERIOD_NS < 1) ? 1 :
    BMA_SYNC_MAX_NS / BMA_CLK_PERIOD_NS;
  localparam logic [1:0] BMA_FIRST_STATE_DELAY = 2'h2;
  localparam logic [1:0] BMA_REGRANT_GAP = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic BMA_GRANT_RST = 1'h0;
  localparam logic BMA_FLOAT_RST = 1'h0;

  // ==========================================================================
  // arbiter states, one-hot
  typedef enum logic [4:0] {
    BMA_ST_IDLE = 5'h01,
    BMA_ST_WAIT_CYCLE = 5'h02,
    BMA_ST_GRANT = 5'h04,
    BMA_ST_OWNED = 5'h08,
    BMA_ST_GAP = 5'h10
  } bma_state_t;

endpackage

// File: rtl/bma_sync.sv
// Purpose: falling-edge sampler for asynchronous arbitration inputs
// Assumes: inputs meet setup to the clock
// Notes: emulates sample-on-fall, valid-at-next-fall with a 2-stage chain
`timescale 1ns/1ps
module bma_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_sync
);
  import bma_pkg::*;

  logic meta_q;
  logic sync_q;

  // ==========================================================================
  // sampler
  // first stage feeds only the second stage
  always_ff @(negedge i_clk) begin
    if (!i_reset_n) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// File: rtl/bma_arbiter.sv
// Purpose: bus mastership arbiter of the processor's external bus
// Assumes: request/acknowledge active high; bus sequencer gives cycle status
// Notes: i_three_wire low selects the two-wire variant
//
// Behaviour
// - two-wire variant ignores grant_ack entirely
// - finish started cycle, then yield bus
// - drop grant_out after grant_ack seen
// - re-grant while request_in still asserted
// - request withdrawn before acknowledge resumes processing
// - grant right after request synchronised
// - committed cycle delays grant until addr_strobe or one skipped rising edge, whichever comes first
// - grant_ack holder owns bus until negation
// - no bus cycle between release and re-grant
// - inputs synchronised within one clock
// - sample falling edge, valid next fall
// - outputs change on following rising edge
// - float buses when control set, strobe negated and no cycle active
// - first_bus_state request grants second rising edge
`timescale 1ns/1ps
module bma_arbiter (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_three_wire,
  input wire logic i_request_in,
  input wire logic i_grant_ack,
  input wire logic i_first_bus_state,
  input wire logic i_addr_strobe,
  input wire logic i_cycle_active,
  output logic o_grant_out,
  output logic o_three_state,
  output logic o_bus_float,
  output logic o_bus_hold
);
  import bma_pkg::*;

  // ==========================================================================
  // input synchronisers
  logic req_s;
  logic ack_raw_s;
  logic ack_s;

  bma_sync u_req_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_request_in),
    .o_sync(req_s)
  );

  bma_sync u_ack_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_grant_ack),
    .o_sync(ack_raw_s)
  );

  assign ack_s = i_three_wire & ack_raw_s;

  // ==========================================================================
  // state and registers
  bma_state_t state_q;
  bma_state_t state_d;
  logic grant_q;
  logic grant_d;
  logic tri_q;
  logic tri_d;
  logic float_q;
  logic float_d;
  logic hold_q;
  logic hold_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic s0_seen_q;
  logic s0_seen_d;

  // committed cycle without strobe yet delays the grant
  wire committed = i_first_bus_state & ~i_addr_strobe;
  wire delay_done = (cnt_q >= BMA_FIRST_STATE_DELAY - 2'h1);
  wire may_grant = ~committed | delay_done;

  // ==========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    s0_seen_d = s0_seen_q;
    unique case (state_q)
      BMA_ST_IDLE: begin
        cnt_d = 2'h0;
        s0_seen_d = 1'h0;
        if (req_s && !ack_s) begin
          if (committed) begin
            state_d = BMA_ST_WAIT_CYCLE;
            s0_seen_d = 1'h1;
          end else begin
            state_d = BMA_ST_GRANT;
          end
        end else if (ack_s) begin
          state_d = BMA_ST_OWNED;
        end
      end
      BMA_ST_WAIT_CYCLE: begin
        // grant once strobe is up, or after skipping one rising edge without it
        if (cnt_q != 2'h3) begin
          cnt_d = cnt_q + 2'h1;
        end
        if (!req_s) begin
          state_d = BMA_ST_IDLE;
        end else if (may_grant || i_addr_strobe) begin
          state_d = BMA_ST_GRANT;
        end
      end
      BMA_ST_GRANT: begin
        if (ack_s) begin
          state_d = BMA_ST_OWNED;
        end else if (!req_s) begin
          state_d = BMA_ST_IDLE;
        end
      end
      BMA_ST_OWNED: begin
        cnt_d = 2'h0;
        if (!ack_s) begin
          state_d = BMA_ST_GAP;
        end else if (req_s) begin
          state_d = BMA_ST_OWNED;
        end
      end
      BMA_ST_GAP: begin
        // bus stays held so no cycle slips in before a re-grant
        cnt_d = cnt_q + 2'h1;
        if (ack_s) begin
          state_d = BMA_ST_OWNED;
        end else if (cnt_q == BMA_REGRANT_GAP - 2'h1) begin
          state_d = req_s ? BMA_ST_GRANT : BMA_ST_IDLE;
        end
      end
      default: begin
        state_d = BMA_ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // outputs
  always_comb begin
    grant_d = 1'h0;
    tri_d = 1'h0;
    hold_d = 1'h0;
    unique case (state_d)
      BMA_ST_IDLE: begin
        grant_d = 1'h0;
      end
      BMA_ST_WAIT_CYCLE: begin
        hold_d = 1'h0;
      end
      BMA_ST_GRANT: begin
        grant_d = 1'h1;
        tri_d = ~i_three_wire;
        hold_d = 1'h1;
      end
      BMA_ST_OWNED: begin
        grant_d = 1'h0;
        tri_d = 1'h1;
        hold_d = 1'h1;
      end
      BMA_ST_GAP: begin
        tri_d = 1'h1;
        hold_d = 1'h1;
      end
      default: begin
        grant_d = 1'h0;
      end
    endcase
  end

  // float only once the running cycle has dropped its strobe
  assign float_d = tri_d & ~i_addr_strobe & ~i_cycle_active;

  // ==========================================================================
  // registers, all on the rising edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= BMA_ST_IDLE;
      cnt_q <= 2'h0;
      s0_seen_q <= 1'h0;
      grant_q <= BMA_GRANT_RST;
      tri_q <= BMA_FLOAT_RST;
      float_q <= BMA_FLOAT_RST;
      hold_q <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      s0_seen_q <= s0_seen_d;
      grant_q <= grant_d;
      tri_q <= tri_d;
      float_q <= float_d;
      hold_q <= hold_d;
    end
  end

  assign o_grant_out = grant_q;
  assign o_three_state = tri_q;
  assign o_bus_float = float_q;
  assign o_bus_hold = hold_q;
endmodule

// File: verification/bma_arbiter_chk.sv
// Purpose: port checker for the bus mastership arbiter
// Assumes: bound to bma_arbiter, one clock domain
// Notes: bounds allow the 2-3 edge synchroniser latency
`timescale 1ns/1ps
module bma_arbiter_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_three_wire,
  input wire logic i_request_in,
  input wire logic i_grant_ack,
  input wire logic i_first_bus_state,
  input wire logic i_addr_strobe,
  input wire logic i_cycle_active,
  input wire logic o_grant_out,
  input wire logic o_three_state,
  input wire logic o_bus_float,
  input wire logic o_bus_hold
);
  // ========
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_grant_fast: assert property ($rose(i_request_in) && !i_first_bus_state &&
    !i_cycle_active && !o_bus_hold && !o_grant_out |-> ##[1:3] o_grant_out) else $error("late");
  a_first_skip: assert property ($rose(i_request_in) && i_first_bus_state &&
    !i_addr_strobe |=> !o_grant_out) else $error("grant in first state");
  a_ack_drops: assert property (i_three_wire && o_grant_out && i_grant_ack
    |-> ##[1:4] !o_grant_out) else $error("grant kept after ack");
  a_two_keep: assert property (!i_three_wire && i_request_in && o_grant_out
    |=> o_grant_out) else $error("two-wire grant lost");
  a_two_drop: assert property (!i_three_wire && !i_request_in && o_grant_out
    |-> ##[1:4] !o_grant_out) else $error("two-wire grant stuck");
  a_idle_free: assert property ((!i_request_in && !i_grant_ack) [*8]
    |-> !o_grant_out && !o_bus_hold) else $error("bus not resumed");
  a_regrant_due: assert property (i_three_wire && $fell(i_grant_ack) && i_request_in
    |-> ##[1:8] o_grant_out) else $error("no regrant");
  a_gap_hold: assert property (i_three_wire && $fell(i_grant_ack) && i_request_in
    |-> o_bus_hold [*3]) else $error("cycle in gap");
  a_float_set: assert property (o_three_state && !i_addr_strobe && !i_cycle_active ##1
    o_three_state && !i_addr_strobe && !i_cycle_active |-> o_bus_float) else $error("no float");
  c_regrant: cover property (i_three_wire && $fell(i_grant_ack) && i_request_in);
  c_two_ack: cover property (!i_three_wire && o_grant_out && i_grant_ack);
  c_first: cover property ($rose(i_request_in) && i_first_bus_state);
endmodule
bind bma_arbiter bma_arbiter_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_three_wire(i_three_wire), .i_request_in(i_request_in), .i_grant_ack(i_grant_ack),
  .i_first_bus_state(i_first_bus_state), .i_addr_strobe(i_addr_strobe),
  .i_cycle_active(i_cycle_active), .o_grant_out(o_grant_out), .o_three_state(o_three_state),
  .o_bus_float(o_bus_float), .o_bus_hold(o_bus_hold));

// File: verification/bma_master.sv
// Purpose: external bus master claiming the bus once per enable
// Assumes: bench request is wire-ORed beside it
// Notes: ack held six clocks; i_again keeps request pending
`timescale 1ns/1ps
module bma_master (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_again,
  input wire logic i_grant,
  input wire logic i_addr_strobe,
  output logic o_req,
  output logic o_ack
);
  // ========
  // ownership sequence
  int cnt = 0;
  initial o_req = 1'h0;
  initial o_ack = 1'h0;
  always @(posedge i_clk) begin
    if (!i_en) begin
      o_req <= 1'h0;
      o_ack <= 1'h0;
      cnt <= 0;
    end else if (!o_ack) begin
      o_req <= (cnt == 0) || i_again;
      // no break-in while strobe is up
      if (i_grant && !i_addr_strobe && cnt == 0) begin
        o_ack <= 1'h1;
        cnt <= 1;
      end
    end else begin
      o_req <= i_again;
      cnt <= cnt + 1;
      if (cnt == 6) o_ack <= 1'h0;
    end
  end
endmodule

// File: verification/tb_bus_mastership_arbiter.sv
// Purpose: self-checking bench for the bus mastership arbiter
// Assumes: inputs driven on rising edge, outputs read on falling edge
// Notes: bench request wire-ORed with the partner's
`timescale 1ns/1ps
module tb_bus_mastership_arbiter;
  logic i_clk = 0, i_reset_n = 0, three_w = 0, b_req = 0, fbs = 0, strobe = 0, cyc = 0;
  logic m_en = 0, again = 0, m_req, m_ack, grant, tri_st, flt, hold;
  int error_cnt = 0, n_compared = 0;
  always #50 i_clk = ~i_clk;
  bma_arbiter u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_three_wire(three_w),
    .i_request_in(b_req | m_req), .i_grant_ack(m_ack), .i_first_bus_state(fbs),
    .i_addr_strobe(strobe), .i_cycle_active(cyc), .o_grant_out(grant),
    .o_three_state(tri_st), .o_bus_float(flt), .o_bus_hold(hold));
  bma_master u_far (.i_clk(i_clk), .i_en(m_en), .i_again(again), .i_grant(grant),
    .i_addr_strobe(strobe), .o_req(m_req), .o_ack(m_ack));
  // ========
  // helpers
  task chk(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wgrant(input logic v);
    int k;
    k = 0;
    while (grant !== v && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    chk(v, grant);
  endtask
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ========
  // scenarios
  task t_two;
    @(posedge i_clk) three_w <= 1'h0;
    again <= 1'h1;
    m_en <= 1'h1;
    wgrant(1);
    repeat (4) @(negedge i_clk);
    chk(1, grant);
    chk(1, tri_st);
    @(posedge i_clk) m_en <= 1'h0;
    wgrant(0);
    $display("two-wire test done");
  endtask
  task automatic t_three(input logic a);
    @(posedge i_clk) three_w <= 1'h1;
    again <= a;
    m_en <= 1'h1;
    wgrant(1);
    wgrant(0);
    @(negedge i_clk) chk(1, flt);
    chk(1, tri_st);
    // ack drop, sync and gap all fit inside 16 clocks
    repeat (16) @(negedge i_clk);
    chk(a, grant);
    chk(a, hold);
    @(posedge i_clk) m_en <= 1'h0;
    repeat (10) @(negedge i_clk);
    chk(0, hold);
    $display("three-wire test done");
  endtask
  task t_first;
    @(posedge i_clk) fbs <= 1'h1;
    cyc <= 1'h1;
    b_req <= 1'h1;
    repeat (3) @(negedge i_clk);
    chk(0, grant);
    @(posedge i_clk) strobe <= 1'h1;
    fbs <= 1'h0;
    wgrant(1);
    @(posedge i_clk) strobe <= 1'h0;
    cyc <= 1'h0;
    b_req <= 1'h0;
    repeat (10) @(negedge i_clk);
    chk(0, grant);
    $display("first-state test done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'h1;
    repeat (2) @(negedge i_clk);
    chk(0, grant);
    t_two();
    t_three(1'h1);
    t_three(1'h0);
    t_first();
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
